// ==== bench/test_io_port_watchdog_timer.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_io_port_watchdog_timer;
  localparam int unsigned TC = 10;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic        io_wr = 1'b0;
  logic        io_rd = 1'b0;
  logic [7:0]  io_wdata = 8'h00;
  logic        action_sel = 1'b0;
  logic [7:0]  io_rdata;
  logic        wd_enabled;
  logic [7:0]  seconds_left;
  logic        cpu_reset_req;
  logic        irq_req;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cycles = 0;
  // ==========================================
  // Short time base so a 62 s expiry fits the run
  iwd_top #(.TICK_CYCLES(TC)) iwd_top_inst (.clk_sys(clk_sys), .resetn(resetn), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .action_sel(action_sel),
    .wd_enabled(wd_enabled), .seconds_left(seconds_left), .cpu_reset_req(cpu_reset_req), .irq_req(irq_req));
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Ceiling well above the roughly 930 cycles the tests need
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  // ==========================================
  // One-cycle strobes, driven off the sampling edge
  task automatic io_acc(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    io_addr = a;
    io_wdata = d;
    io_wr = wr;
    io_rd = !wr;
    @(negedge clk_sys);
    io_wr = 1'b0;
    io_rd = 1'b0;
  endtask
  task automatic quiet(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      chk(cpu_reset_req === 1'b0 && irq_req === 1'b0, "early expiry");
    end
  endtask
  task automatic wait_pulse(input int n, input logic irq);
    int k;
    k = 0;
    while (cpu_reset_req !== 1'b1 && irq_req !== 1'b1 && k < n * TC + 5) begin
      @(negedge clk_sys);
      k++;
    end
    chk(k >= n * TC - 1 && k <= n * TC + 2, "expiry time");
    chk(irq_req === irq && cpu_reset_req === !irq, "expiry action");
    @(negedge clk_sys);
    chk(cpu_reset_req === 1'b0 && irq_req === 1'b0 && wd_enabled === 1'b0, "after expiry");
  endtask
  task automatic t_reset();
    chk(wd_enabled === 1'b0 && seconds_left === 8'h00 && cpu_reset_req === 1'b0, "reset");
    io_acc(1'b1, 16'h0442, 8'h02);
    chk(wd_enabled === 1'b0, "other address");
    $display("test reset done");
  endtask
  task automatic t_expiry();
    io_acc(1'b1, 16'h0443, 8'h02);
    chk(wd_enabled === 1'b1 && seconds_left === 8'h02, "load");
    wait_pulse(2, 1'b0);
    action_sel = 1'b1;
    io_acc(1'b1, 16'h0443, 8'h3E);
    chk(seconds_left === 8'h3E, "max code");
    wait_pulse(62, 1'b1);
    $display("test expiry done");
  endtask
  task automatic t_refresh();
    io_acc(1'b1, 16'h0443, 8'h01);
    quiet(7);
    io_acc(1'b1, 16'h0443, 8'h01);
    chk(seconds_left === 8'h01 && wd_enabled === 1'b1, "reload");
    wait_pulse(1, 1'b1);
    $display("test refresh done");
  endtask
  task automatic t_read();
    io_acc(1'b1, 16'h0443, 8'h05);
    io_acc(1'b0, 16'h0444, 8'h00);
    chk(wd_enabled === 1'b1, "read other address");
    io_acc(1'b0, 16'h0443, 8'h00);
    chk(wd_enabled === 1'b0 && io_rdata === 8'h05, "read disables");
    quiet(70);
    $display("test read done");
  endtask
  task automatic t_midreset();
    io_acc(1'b1, 16'h0443, 8'h05);
    @(negedge clk_sys);
    resetn = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk(wd_enabled === 1'b0 && seconds_left === 8'h00 && io_rdata === 8'h00, "mid-run reset");
    resetn = 1'b1;
    quiet(60);
    $display("test mid-run reset done");
  endtask
  task automatic t_bad();
    logic [7:0] codes [3];
    codes = '{8'h00, 8'h3F, 8'hFF};
    foreach (codes[i]) begin
      io_acc(1'b1, 16'h0443, 8'h02);
      io_acc(1'b1, 16'h0443, codes[i]);
      chk(wd_enabled === 1'b0, "bad code");
      quiet(30);
    end
    $display("test bad codes done");
  endtask
  initial begin
    repeat (16) @(negedge clk_sys);
    chk(wd_enabled === 1'b0 && irq_req === 1'b0, "in reset");
    resetn = 1'b1;
    t_reset();
    t_expiry();
    t_refresh();
    t_read();
    t_midreset();
    t_bad();
    give_verdict();
  end
endmodule
`default_nettype wire

// ==== src/iwd_pkg.sv ====
`default_nettype none
package iwd_pkg;
  // ==========================================
  // Port map
  localparam logic [15:0] WD_PORT_ADDR    = 16'h0443;
  localparam logic [7:0]  CODE_MIN        = 8'h01;
  localparam logic [7:0]  CODE_MAX        = 8'h3E;
  localparam logic [7:0]  INTERVAL_RESET  = 8'h00;
  // ==========================================
  // Timing
  localparam int          CLK_HZ          = 100_000_000;
  localparam int          TICK_SEC_MS     = 1000;
  localparam int          TICK_CYCLES     = (CLK_HZ / 1000) * TICK_SEC_MS;
  // ==========================================
  // Expiry action selector
  localparam logic        ACT_RESET       = 1'b0;
  localparam logic        ACT_IRQ         = 1'b1;
  // ==========================================
  // Controller states
  typedef enum logic [0:0] {
    IWD_IDLE = 1'b0,
    IWD_RUN  = 1'b1
  } iwd_state_t;
endpackage
`default_nettype wire

// ==== src/iwd_tick.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Seconds time base, restarted on every reload
module iwd_tick #(
  parameter int unsigned TICK_CYCLES = 100_000_000
) (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic restart,
  output logic      tick
);
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic        next_tick;

  always_comb begin
    next_cnt  = cnt + 32'h00000001;
    next_tick = 1'b0;
    if (restart) begin
      next_cnt = 32'h00000000;
    end else if (cnt == 32'(TICK_CYCLES - 1)) begin
      next_cnt  = 32'h00000000;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cnt  <= 32'h00000000;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule
`default_nettype wire

// ==== src/iwd_top.sv ====
// Notes on behaviour
// - Write to the watchdog port loads the byte as interval; a valid code starts counting, any other code stops it.
// - Valid codes 0x01 to 0x3E, one second per count, 1 to 62 s.
// - Each further write of a valid code reloads and restarts; software must refresh in time.
// - Any read of the port disables the watchdog until the next write.
// - Expiry without refresh resets the CPU or raises an interrupt, per selection.
`timescale 1ns/10ps
`default_nettype none
module iwd_top #(
  parameter int unsigned TICK_CYCLES = iwd_pkg::TICK_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  input  wire logic        action_sel,
  output logic             wd_enabled,
  output logic      [7:0]  seconds_left,
  output logic             cpu_reset_req,
  output logic             irq_req
);
  // ==========================================
  // Port decode
  logic hit_wr;
  logic hit_rd;
  logic tick;
  assign hit_wr = io_wr && (io_addr == iwd_pkg::WD_PORT_ADDR);
  assign hit_rd = io_rd && (io_addr == iwd_pkg::WD_PORT_ADDR);

  function automatic logic code_ok(input logic [7:0] c);
    code_ok = (c >= iwd_pkg::CODE_MIN) && (c <= iwd_pkg::CODE_MAX);
  endfunction

  iwd_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .restart (hit_wr),
    .tick    (tick)
  );

  // ==========================================
  // Countdown control
  iwd_pkg::iwd_state_t state;
  iwd_pkg::iwd_state_t next_state;
  logic [7:0] interval;
  logic [7:0] next_interval;
  logic [7:0] remain;
  logic [7:0] next_remain;
  logic [7:0] next_rdata;
  logic       next_cpu_reset;
  logic       next_irq;

  always_comb begin
    next_state     = state;
    next_interval  = interval;
    next_remain    = remain;
    next_rdata     = io_rdata;
    next_cpu_reset = 1'b0;
    next_irq       = 1'b0;
    if (hit_rd) begin
      next_state = iwd_pkg::IWD_IDLE;
      next_rdata = interval;
    end else if (hit_wr) begin
      next_interval = io_wdata;
      next_remain   = io_wdata;
      if (code_ok(io_wdata)) begin
        next_state = iwd_pkg::IWD_RUN;
      end else begin
        next_state = iwd_pkg::IWD_IDLE;
      end
    end else begin
      unique case (state)
        iwd_pkg::IWD_IDLE: begin
          next_remain = remain;
        end
        iwd_pkg::IWD_RUN: begin
          if (tick) begin
            if (remain == 8'h01) begin
              // One-shot: after firing the dog stays off so no reset storm
              next_remain = 8'h00;
              next_state  = iwd_pkg::IWD_IDLE;
              if (action_sel == iwd_pkg::ACT_IRQ) begin
                next_irq = 1'b1;
              end else begin
                next_cpu_reset = 1'b1;
              end
            end else begin
              next_remain = remain - 8'h01;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state         <= iwd_pkg::IWD_IDLE;
      interval      <= iwd_pkg::INTERVAL_RESET;
      remain        <= 8'h00;
      io_rdata      <= 8'h00;
      cpu_reset_req <= 1'b0;
      irq_req       <= 1'b0;
    end else begin
      state         <= next_state;
      interval      <= next_interval;
      remain        <= next_remain;
      io_rdata      <= next_rdata;
      cpu_reset_req <= next_cpu_reset;
      irq_req       <= next_irq;
    end
  end

  assign wd_enabled   = (state == iwd_pkg::IWD_RUN);
  assign seconds_left = remain;

  // ==========================================
  // Seconds spacing monitor, kept apart from the time base so the checks do not trust it
  logic [31:0] tick_gap;
  logic [31:0] next_tick_gap;

  always_comb begin
    next_tick_gap = tick_gap + 32'h00000001;
    if (hit_wr) begin
      next_tick_gap = 32'h00000000;
    end else if (tick) begin
      next_tick_gap = 32'h00000001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      tick_gap <= 32'h00000000;
    end else begin
      tick_gap <= next_tick_gap;
    end
  end

  // ==========================================
  // Checks
  property p_load;
    @(posedge clk_sys) disable iff (!resetn)
      (hit_wr && !hit_rd && code_ok(io_wdata)) |=> (wd_enabled && seconds_left == $past(io_wdata));
  endproperty
  a_load: assert property (p_load) else $error("write did not start countdown");

  property p_range;
    @(posedge clk_sys) disable iff (!resetn)
      wd_enabled |-> (seconds_left >= 8'h01 && seconds_left <= 8'h3E);
  endproperty
  a_range: assert property (p_range) else $error("count out of range while running");

  property p_restart;
    @(posedge clk_sys) disable iff (!resetn)
      (hit_wr && !hit_rd) |=> !cpu_reset_req && !irq_req;
  endproperty
  a_restart: assert property (p_restart) else $error("expiry despite refresh");

  property p_disable;
    @(posedge clk_sys) disable iff (!resetn)
      hit_rd |=> (!wd_enabled && !cpu_reset_req && !irq_req);
  endproperty
  a_disable: assert property (p_disable) else $error("read did not disable");

  property p_expire;
    @(posedge clk_sys) disable iff (!resetn)
      (wd_enabled && tick && seconds_left == 8'h01 && !io_wr && !io_rd)
        |=> ((cpu_reset_req ^ irq_req) && irq_req == $past(action_sel) && !wd_enabled);
  endproperty
  a_expire: assert property (p_expire) else $error("expiry action wrong");

  property p_bad_code;
    @(posedge clk_sys) disable iff (!resetn)
      (hit_wr && !hit_rd && !code_ok(io_wdata)) |=> !wd_enabled;
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("bad code left timer on");

  property p_only_on_run;
    @(posedge clk_sys) disable iff (!resetn)
      $rose(cpu_reset_req) || $rose(irq_req) |-> $past(wd_enabled) && $past(tick);
  endproperty
  a_only_on_run: assert property (p_only_on_run) else $error("action without running tick");

  property p_idle_holds;
    @(posedge clk_sys) disable iff (!resetn)
      (!wd_enabled && !io_wr) |=> !wd_enabled;
  endproperty
  a_idle_holds: assert property (p_idle_holds) else $error("started without write");

  property p_tick_period;
    @(posedge clk_sys) disable iff (!resetn)
      tick |-> (tick_gap == 32'(TICK_CYCLES));
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("second tick off period");

  property p_tick_missing;
    @(posedge clk_sys) disable iff (!resetn)
      tick_gap <= 32'(TICK_CYCLES);
  endproperty
  a_tick_missing: assert property (p_tick_missing) else $error("second tick missing");

  property p_step;
    @(posedge clk_sys) disable iff (!resetn)
      (wd_enabled && tick && seconds_left > 8'h01 && !hit_wr && !hit_rd)
        |=> (wd_enabled && seconds_left == $past(seconds_left) - 8'h01);
  endproperty
  a_step: assert property (p_step) else $error("count did not step down on tick");

  property p_hold;
    @(posedge clk_sys) disable iff (!resetn)
      (wd_enabled && !tick && !hit_wr && !hit_rd) |=> (wd_enabled && $stable(seconds_left));
  endproperty
  a_hold: assert property (p_hold) else $error("count moved without tick");

  property p_read_data;
    @(posedge clk_sys) disable iff (!resetn)
      hit_rd |=> (io_rdata == $past(interval));
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data not the interval");

  property p_rdata_hold;
    @(posedge clk_sys) disable iff (!resetn)
      !hit_rd |=> $stable(io_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");

  property p_pulse_short;
    @(posedge clk_sys) disable iff (!resetn)
      (cpu_reset_req || irq_req) |=> (!cpu_reset_req && !irq_req);
  endproperty
  a_pulse_short: assert property (p_pulse_short) else $error("expiry pulse too long");

  property p_no_action_idle;
    @(posedge clk_sys) disable iff (!resetn)
      !wd_enabled |=> (!cpu_reset_req && !irq_req);
  endproperty
  a_no_action_idle: assert property (p_no_action_idle) else $error("action while disabled");

  property p_reset_clears;
    @(posedge clk_sys)
      !resetn |=> (!wd_enabled && seconds_left == 8'h00 && !cpu_reset_req && !irq_req && io_rdata == 8'h00);
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("reset left timer active");
endmodule
`default_nettype wire
